// ===== rtl/irs_pkg.sv
// ************************************************************
// shared constants
// ************************************************************
package irs_pkg;

  localparam int          ADDR_W       = 13;
  localparam int          INSTR_W      = 16;
  localparam int          OPC_W        = 3;

  localparam logic [2:0]  JUMP_OPC     = 3'h7;
  localparam logic [2:0]  XEC_OPC      = 3'h4;

  localparam logic [15:0] OP_SET_MASK  = 16'h0505;
  localparam logic [15:0] OP_CLR_MASK  = 16'h0404;
  localparam logic [15:0] OP_RETURN    = 16'h0606;
  localparam logic [15:0] OP_PUSH      = 16'h0303;
  localparam logic [15:0] OP_CLR_INT   = 16'h0202;

  localparam logic [12:0] VEC_BASE     = 13'h0004;
  localparam logic [12:0] ADDR_ZERO    = 13'h0000;
  localparam logic [12:0] PUSH_LSB     = 13'h0001;

  localparam logic [1:0]  PUSH_SUSP    = 2'h2;
  localparam logic [1:0]  RET_SUSP     = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INT1,
    ST_INT2,
    ST_RET1,
    ST_RET2
  } irs_state_t;

endpackage

// ===== rtl/irs_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: start servicing pending unmasked request only at processor clock rising edge
// RQ2: set interrupt mask on the rising edge opening service cycle 1
// RQ3: hold processor stall low for one instruction cycle from service cycle 1
// RQ4: raise program memory disable from service cycle 1
// RQ5: at falling edge in service cycle 1 push next address onto stack
// RQ6: from service cycle 2 drive jump to vector 4, 5 or 6
// RQ7: release processor stall high from service cycle 2
// RQ8: from service cycle 3 release instruction bus and program memory disable
// RQ9: after return decode, inhibit servicing from return cycle 1 through cycle 3
// RQ10: from return cycle 1 stall processor and disable program memory
// RQ11: from return cycle 2 release stall, jump to stack top, pop
// RQ12: from return cycle 3 release instruction bus and program memory disable
// RQ13: at return cycle 3 clear mask only for popped interrupt entries
// RQ14: synchronise request and inhibit inputs safely against the processor clock
// RQ15: near-edge request or inhibit changes act now or next cycle, never lost
// RQ16: edges during a latch clear may be dropped, later ones always latched
// RQ17: each return pops exactly one stack entry
// RQ18: software clears mask inside a routine to allow preemption
// RQ19: four-entry stack with flag, overwrite oldest when full, full flag
// RQ20: decode return pattern from instruction bus
// RQ21: address zero resets drivers, outputs, latches, mask and stack; code clears the full flag but not the state or pin drivers
// RQ22: inhibit input blocks servicing without touching the mask
// RQ23: request 0 has priority over 1, then 2
// RQ24: requests latch on rising edge, held while blocked, cleared on service
module irs_sequencer
  import irs_pkg::*;
#(
  parameter int NUM_REQ     = 3,
  parameter int STACK_DEPTH = 4
) (
  input  wire logic               clk_sys_in,
  input  wire logic               resetn_in,
  input  wire logic               mclk_in,
  input  wire logic [NUM_REQ-1:0] int_req_in,
  input  wire logic               interrupt_inhibit_in,
  input  wire logic [ADDR_W-1:0]  addr_in,
  input  wire logic [INSTR_W-1:0] instr_in,
  output logic      [INSTR_W-1:0] instr_out,
  output logic                    instr_oe_out,
  output logic                    processor_stall_n_out,
  output logic                    program_memory_disable_out,
  output logic                    stack_full_flag_out
);

  localparam int NSYNC = NUM_REQ + 2;
  localparam int IDX_W = (NUM_REQ > 1) ? $clog2(NUM_REQ) : 1;
  localparam int CNT_W = $clog2(STACK_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // ************************************************************
  // parameter checks
  // ************************************************************
  if (NUM_REQ < 1 || NUM_REQ > 8) begin : g_chk_req
    $error("NUM_REQ must be 1 to 8");
  end
  if (STACK_DEPTH < 2) begin : g_chk_depth
    $error("STACK_DEPTH must be at least 2");
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [NSYNC-1:0]   async_w;
  logic [NSYNC-1:0]   s1_r;
  logic [NSYNC-1:0]   s2_r;
  logic [NSYNC-1:0]   s3_r;
  logic [NSYNC-1:0]   filt_r;
  logic [NSYNC-1:0]   rise_w;
  logic [NSYNC-1:0]   fall_w;

  assign async_w = {mclk_in, interrupt_inhibit_in, int_req_in};

  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
        s1_r[g]   <= 1'b0;
        s2_r[g]   <= 1'b0;
        s3_r[g]   <= 1'b0;
        filt_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= async_w[g]; // RQ14
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          filt_r[g] <= s2_r[g]; // RQ15
        end
      end
    end
    assign rise_w[g] = s2_r[g] & s3_r[g] & ~filt_r[g];
    assign fall_w[g] = ~s2_r[g] & ~s3_r[g] & filt_r[g];
  end

  logic               mclk_rise;
  logic               mclk_fall;
  logic               inhib_lvl;
  logic [NUM_REQ-1:0] req_rise;

  assign mclk_rise = rise_w[NSYNC-1];
  assign mclk_fall = fall_w[NSYNC-1];
  assign inhib_lvl = filt_r[NSYNC-2];
  assign req_rise  = rise_w[NUM_REQ-1:0];

  // ************************************************************
  // bus alignment with the clock synchroniser
  // ************************************************************
  logic [ADDR_W-1:0]  addr_p1_r;
  logic [ADDR_W-1:0]  addr_p2_r;
  logic [ADDR_W-1:0]  addr_s_r;
  logic [INSTR_W-1:0] instr_p1_r;
  logic [INSTR_W-1:0] instr_p2_r;
  logic [INSTR_W-1:0] instr_s_r;

  always_ff @(posedge clk_sys_in) begin
    addr_p1_r  <= addr_in;
    addr_p2_r  <= addr_p1_r;
    addr_s_r   <= addr_p2_r;
    instr_p1_r <= instr_in;
    instr_p2_r <= instr_p1_r;
    instr_s_r  <= instr_p2_r;
  end

  // ************************************************************
  // decode
  // ************************************************************
  irs_state_t         state_r;
  irs_state_t         state_nxt;
  logic               mask_r;
  logic               ret_req_r;
  logic               xec_r;
  logic               at_zero_r;
  logic               ret_flag_r;
  logic [1:0]         susp_cnt_r;
  logic [NUM_REQ-1:0] req_r;
  logic [IDX_W-1:0]   idx_w;
  logic [ADDR_W-1:0]  vec_r;

  logic               init_p;
  logic               dec_ok;
  logic               dec_ret;
  logic               dec_push;
  logic               dec_set;
  logic               dec_clr;
  logic               dec_clri;
  logic               dec_xec;
  logic               service_ok;
  logic               start_int;
  logic               start_ret;
  logic               ret_done;

  assign init_p     = mclk_rise && (addr_s_r == ADDR_ZERO); // RQ21
  assign dec_ok     = mclk_fall && (state_r == ST_IDLE) && !at_zero_r;
  assign dec_ret    = dec_ok && (instr_s_r == OP_RETURN); // RQ20
  assign dec_push   = dec_ok && (instr_s_r == OP_PUSH);
  assign dec_set    = dec_ok && (instr_s_r == OP_SET_MASK);
  assign dec_clr    = dec_ok && (instr_s_r == OP_CLR_MASK);
  assign dec_clri   = dec_ok && (instr_s_r == OP_CLR_INT);
  assign dec_xec    = dec_ok && (instr_s_r[INSTR_W-1 -: OPC_W] == XEC_OPC);
  assign service_ok = (req_r != '0) && !mask_r && !inhib_lvl // RQ22
                      && (susp_cnt_r == 2'h0) && !xec_r && !ret_req_r; // RQ9
  assign start_ret  = mclk_rise && !init_p && (state_r == ST_IDLE) && ret_req_r;
  assign start_int  = mclk_rise && !init_p && (state_r == ST_IDLE) && service_ok; // RQ1
  assign ret_done   = mclk_rise && (state_r == ST_RET2);

  // lowest index wins
  always_comb begin
    idx_w = '0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (req_r[i]) begin
        idx_w = IDX_W'(i); // RQ23
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    if (mclk_rise) begin
      case (state_r)
        ST_IDLE: begin
          if (start_ret) begin
            state_nxt = ST_RET1; // RQ10
          end else if (start_int) begin
            state_nxt = ST_INT1;
          end
        end
        ST_INT1: state_nxt = ST_INT2;
        ST_INT2: state_nxt = ST_IDLE;
        ST_RET1: state_nxt = ST_RET2;
        ST_RET2: state_nxt = ST_IDLE;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // mask, return request and suspension
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || init_p) begin
      mask_r     <= 1'b1; // RQ21
      ret_req_r  <= 1'b0;
      xec_r      <= 1'b0;
      susp_cnt_r <= 2'h0;
    end else begin
      if (start_int) begin
        mask_r <= 1'b1; // RQ2
      end else if (ret_done && ret_flag_r) begin
        mask_r <= 1'b0; // RQ13
      end else if (dec_set) begin
        mask_r <= 1'b1;
      end else if (dec_clr) begin
        mask_r <= 1'b0;
      end
      if (dec_ret) begin
        ret_req_r <= 1'b1;
      end else if (start_ret) begin
        ret_req_r <= 1'b0;
      end
      if (dec_xec) begin
        xec_r <= 1'b1;
      end else if (mclk_rise) begin
        xec_r <= 1'b0;
      end
      if (dec_push || dec_ret) begin
        susp_cnt_r <= PUSH_SUSP;
      end else if (ret_done) begin
        susp_cnt_r <= RET_SUSP; // RQ9
      end else if (mclk_rise && susp_cnt_r != 2'h0) begin
        susp_cnt_r <= susp_cnt_r - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      at_zero_r <= 1'b1;
      vec_r     <= VEC_BASE;
    end else begin
      if (mclk_rise) begin
        at_zero_r <= (addr_s_r == ADDR_ZERO);
      end
      if (start_int) begin
        vec_r <= VEC_BASE + ADDR_W'(idx_w); // RQ6
      end
    end
  end

  // ************************************************************
  // request latches
  // ************************************************************
  for (genvar g = 0; g < NUM_REQ; g++) begin : g_req
    logic clr_w;
    assign clr_w = dec_clri || (start_int && (idx_w == IDX_W'(g)));
    always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || init_p) begin
        req_r[g] <= 1'b0; // RQ16
      end else if (req_rise[g]) begin
        req_r[g] <= 1'b1; // RQ24
      end else if (clr_w) begin
        req_r[g] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // return stack
  // ************************************************************
  logic [ADDR_W:0]    stk_r [STACK_DEPTH];
  logic [ADDR_W:0]    push_val;
  logic               push_p;
  logic               pop_p;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;

  assign push_p   = (mclk_fall && state_r == ST_INT1) || dec_push; // RQ5
  assign push_val = dec_push ? {1'b0, addr_s_r | PUSH_LSB} : {1'b1, addr_s_r};
  assign pop_p    = mclk_rise && (state_r == ST_RET1); // RQ17
  assign cnt_nxt  = init_p ? '0 :
                    (push_p && cnt_r != CNT_FULL) ? cnt_r + CNT_ONE :
                    (pop_p && cnt_r != '0) ? cnt_r - CNT_ONE : cnt_r;

  for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stk
    logic [ADDR_W:0] dn_w;
    logic [ADDR_W:0] up_w;
    if (g == 0) begin : g_top
      assign dn_w = push_val;
    end else begin : g_mid
      assign dn_w = stk_r[g-1];
    end
    if (g == STACK_DEPTH - 1) begin : g_bot
      assign up_w = '0;
    end else begin : g_rest
      assign up_w = stk_r[g+1];
    end
    always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || init_p) begin
        stk_r[g] <= '0;
      end else if (push_p) begin
        stk_r[g] <= dn_w; // RQ19
      end else if (pop_p) begin
        stk_r[g] <= up_w; // RQ11
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cnt_r               <= '0;
      stack_full_flag_out <= 1'b0;
      ret_flag_r          <= 1'b0;
    end else begin
      cnt_r               <= cnt_nxt;
      stack_full_flag_out <= (cnt_nxt == CNT_FULL); // RQ19
      if (pop_p) begin
        ret_flag_r <= stk_r[0][ADDR_W];
      end
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  logic               stall_n_nxt;
  logic               rd_nxt;
  logic               oe_nxt;

  assign stall_n_nxt = !(state_nxt == ST_INT1 || state_nxt == ST_RET1); // RQ3
  assign rd_nxt      = (state_nxt != ST_IDLE); // RQ4
  assign oe_nxt      = (state_nxt == ST_INT2 || state_nxt == ST_RET2); // RQ8

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      processor_stall_n_out      <= 1'b1;
      program_memory_disable_out <= 1'b0;
      instr_oe_out               <= 1'b0;
      instr_out                  <= '0;
    end else begin
      processor_stall_n_out      <= stall_n_nxt; // RQ7
      program_memory_disable_out <= rd_nxt; // RQ12
      instr_oe_out               <= oe_nxt;
      if (mclk_rise && state_r == ST_INT1) begin
        instr_out <= {JUMP_OPC, vec_r}; // RQ6
      end else if (pop_p) begin
        instr_out <= {JUMP_OPC, stk_r[0][ADDR_W-1:0]}; // RQ11
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  service_start_a: assert property ( // RQ1
    start_int |=> state_r == ST_INT1 && mask_r && !processor_stall_n_out
                  && program_memory_disable_out
  ) else $error("service start outputs wrong");

  service_mask_a: assert property ( // RQ2
    (state_r == ST_INT1 || state_r == ST_INT2) |-> mask_r
  ) else $error("mask clear during service");

  vector_jump_a: assert property ( // RQ6
    (mclk_rise && state_r == ST_INT1) |=> instr_oe_out && processor_stall_n_out
      && instr_out == {JUMP_OPC, vec_r}
  ) else $error("vector jump not driven");

  service_release_a: assert property ( // RQ8
    (mclk_rise && state_r == ST_INT2) |=> !instr_oe_out && !program_memory_disable_out
  ) else $error("bus not released after service");

  return_release_a: assert property ( // RQ12
    (mclk_rise && state_r == ST_RET2) |=> !instr_oe_out && !program_memory_disable_out
      && processor_stall_n_out
  ) else $error("bus not released after return");

  return_mask_a: assert property ( // RQ13
    (ret_done && ret_flag_r && !init_p) |=> !mask_r
  ) else $error("mask not cleared on interrupt return");

  inhibit_block_a: assert property ( // RQ22
    (mclk_rise && inhib_lvl) |=> state_r != ST_INT1 || $past(state_r) == ST_INT1
  ) else $error("service started while inhibited");

  pop_one_a: assert property ( // RQ17
    (pop_p && !push_p && cnt_r != '0) |=> cnt_r == $past(cnt_r) - CNT_ONE
  ) else $error("return did not pop one entry");

  stack_full_a: assert property ( // RQ19
    stack_full_flag_out == (cnt_r == CNT_FULL)
  ) else $error("stack full flag mismatch");

  zero_init_a: assert property ( // RQ21
    init_p |=> cnt_r == '0 && mask_r && !stack_full_flag_out && state_r == ST_IDLE
  ) else $error("address zero init incomplete");

  return_hold_a: assert property ( // RQ9
    ret_done |=> !start_int [*2]
  ) else $error("service during return window");

endmodule // irs_sequencer

// ===== test/irs_cpu_model.sv
`timescale 1ns/1ps
// ****
// host processor model
// ****
module irs_cpu_model
  import irs_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               resetn_in,
  input  wire logic               stall_n_in,
  input  wire logic               mem_dis_in,
  input  wire logic               oe_in,
  input  wire logic [INSTR_W-1:0] jump_in,
  output logic                    mclk_out,
  output logic      [ADDR_W-1:0]  addr_out,
  output logic      [INSTR_W-1:0] instr_out
);
  logic [3:0]         div_r;
  logic [ADDR_W-1:0]  pc_r;
  logic [INSTR_W-1:0] last_r;
  logic [INSTR_W-1:0] word;
  logic [INSTR_W-1:0] mem [0:63];
  // device word, memory word, or a floating bus
  assign word      = oe_in ? jump_in : mem[pc_r[5:0]];
  assign instr_out = (oe_in || !mem_dis_in) ? word : ~last_r;
  assign addr_out  = resetn_in ? pc_r + 13'h0001 : 13'h0000;
  assign mclk_out  = resetn_in ? div_r[3] : 1'b0;
  always_ff @(posedge clk_sys_in) begin
    last_r <= instr_out;
    if (!resetn_in) begin
      div_r <= 4'h0;
      pc_r  <= 13'h1FFF;
    end else begin
      div_r <= div_r + 4'h1;
      // advance just after the rise unless halted
      if (div_r == 4'hA && stall_n_in) begin
        pc_r <= (word[15:13] == JUMP_OPC) ? word[12:0] : pc_r + 13'h0001;
      end
    end
  end
endmodule // irs_cpu_model

// ===== test/tb_interrupt_return_sequencer.sv
`timescale 1ns/1ps
// ****
// bench top
// ****
module tb_interrupt_return_sequencer;
  import irs_pkg::*;
  logic               clk_sys;
  logic               resetn;
  logic               mclk;
  logic [2:0]         int_req;
  logic               inhibit;
  logic [ADDR_W-1:0]  addr;
  logic [INSTR_W-1:0] bus;
  logic [INSTR_W-1:0] jword;
  logic               oe;
  logic               stall_n;
  logic               mem_dis;
  logic               full;
  logic               oe_q;
  logic               stall_q;
  logic               dis_q;
  logic [2:0]         r;
  logic [31:0]        seed;
  logic [INSTR_W-1:0] jq[$];
  logic [ADDR_W-1:0]  aq[$];
  int                 n_mismatch;
  int                 n_checks;
  int                 cyc;
  int                 st_len;
  int                 dis_len;

  irs_sequencer i_dut (
    .clk_sys_in                 (clk_sys),
    .resetn_in                  (resetn),
    .mclk_in                    (mclk),
    .int_req_in                 (int_req),
    .interrupt_inhibit_in       (inhibit),
    .addr_in                    (addr),
    .instr_in                   (bus),
    .instr_out                  (jword),
    .instr_oe_out               (oe),
    .processor_stall_n_out      (stall_n),
    .program_memory_disable_out (mem_dis),
    .stack_full_flag_out        (full)
  );

  irs_cpu_model i_cpu (
    .clk_sys_in (clk_sys),
    .resetn_in  (resetn),
    .stall_n_in (stall_n),
    .mem_dis_in (mem_dis),
    .oe_in      (oe),
    .jump_in    (jword),
    .mclk_out   (mclk),
    .addr_out   (addr),
    .instr_out  (bus)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] jump_op(input logic [12:0] t);
    return {JUMP_OPC, t};
  endfunction

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_pc(input int p);
    repeat (5000) begin
      if (i_cpu.pc_r == p) break;
      step(1);
    end
    #1;
  endtask

  task automatic wait_jq(input int n);
    repeat (5000) begin
      if (jq.size() >= n) break;
      step(1);
    end
  endtask

  task automatic pulse(input logic [2:0] v);
    int_req = v;
    step(4);
    int_req = 3'h0;
  endtask

  // each request: vector jump, then return to the stacked address
  task automatic services(input logic [2:0] v);
    int j;
    j = 0;
    wait_jq(2 * $countones(v));
    for (int k = 0; k < 3; k++) begin
      if (v[k]) begin
        chk_val("vector", jump_op(VEC_BASE + 13'(k)), jq[j]);
        chk_val("return", jump_op(aq[j]), jq[j+1]);
        j = j + 2;
      end
    end
    jq.delete();
    aq.delete();
  endtask

  // ****
  // bus monitor
  // ****
  always @(posedge clk_sys) begin
    #2;
    cyc++;
    if (oe && !oe_q) begin
      jq.push_back(jword);
      chk_val("stall_at_jump", 16'h0001, {15'h0, stall_n});
      chk_val("dis_at_jump", 16'h0001, {15'h0, mem_dis});
    end
    if (!mem_dis && dis_q) begin
      chk_val("oe_at_release", 16'h0000, {15'h0, oe});
    end
    if (!stall_n && stall_q) begin
      aq.push_back(addr);
    end
    if (!stall_n) begin
      st_len++;
    end else if (st_len > 0) begin
      chk_cnt("stall_len", 16, st_len);
      st_len = 0;
    end
    if (mem_dis) begin
      dis_len++;
    end else if (dis_len > 0) begin
      chk_cnt("dis_len", 32, dis_len);
      dis_len = 0;
    end
    oe_q = oe;
    stall_q = stall_n;
    dis_q = mem_dis;
    if (cyc == 30000) begin
      n_mismatch++;
      $display("[ERR] run_time expected done seen hang");
      end_of_test();
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    resetn = 1'b0;
    int_req = 3'h0;
    inhibit = 1'b0;
    seed = 32'h0000988E;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    st_len = 0;
    dis_len = 0;
    for (int i = 0; i < 64; i++) i_cpu.mem[i] = 16'h0000;
    for (int k = 0; k < 3; k++) i_cpu.mem[4+k] = jump_op(13'h0010 + 13'(8*k));
    for (int b = 41; b < 58; b += 4) begin
      i_cpu.mem[b] = OP_PUSH;
      i_cpu.mem[b+1] = jump_op(13'(b + 4));
      i_cpu.mem[b+2] = OP_RETURN;
    end
    i_cpu.mem[2] = jump_op(13'h0008);
    i_cpu.mem[14] = jump_op(13'h0008);
    i_cpu.mem[15] = jump_op(13'h0008);
    i_cpu.mem[16] = OP_RETURN;
    i_cpu.mem[24] = OP_RETURN;
    i_cpu.mem[32] = OP_CLR_MASK;
    i_cpu.mem[33] = OP_RETURN;
    i_cpu.mem[47] = jump_op(13'h0008);
    i_cpu.mem[61] = OP_RETURN;
    step(4);
    chk_val("reset_out", 16'h0008, {12'h0, stall_n, mem_dis, oe, full});
    resetn = 1'b1;
    wait_pc(10);
    pulse(3'h7);
    step(320);
    chk_cnt("masked_jumps", 0, jq.size());
    i_cpu.mem[9] = OP_CLR_MASK;
    services(3'h7);
    $display("test masked_priority done");
    inhibit = 1'b1;
    pulse(3'h2);
    step(320);
    chk_cnt("inhibit_jumps", 0, jq.size());
    inhibit = 1'b0;
    services(3'h2);
    $display("test inhibit done");
    repeat (8) begin
      seed = xs(seed);
      r = (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0];
      step(int'(seed[7:4]) + 1);
      pulse(r);
      services(r);
    end
    $display("test random_requests done");
    i_cpu.mem[14] = jump_op(13'd41);
    wait_pc(41);
    i_cpu.mem[14] = jump_op(13'h0008);
    wait_pc(50);
    chk_val("full_three", 16'h0000, {15'h0, full});
    wait_pc(54);
    chk_val("full_four", 16'h0001, {15'h0, full});
    wait_pc(58);
    chk_val("full_over", 16'h0001, {15'h0, full});
    wait_pc(55);
    chk_val("full_popped", 16'h0000, {15'h0, full});
    wait_jq(4);
    for (int k = 0; k < 4; k++) begin
      chk_val("stack_return", jump_op(13'(59 - 4*k)), jq[k]);
    end
    wait_pc(8);
    chk_val("full_empty", 16'h0000, {15'h0, full});
    $display("test stack done");
    jq.delete();
    aq.delete();
    i_cpu.mem[9] = OP_SET_MASK;
    step(64);
    pulse(3'h1);
    step(64);
    i_cpu.mem[10] = OP_CLR_INT;
    step(64);
    i_cpu.mem[10] = 16'h0000;
    i_cpu.mem[9] = OP_CLR_MASK;
    step(320);
    chk_cnt("clear_int_jumps", 0, jq.size());
    $display("test clear_interrupt done");
    end_of_test();
  end
endmodule // tb_interrupt_return_sequencer
